/* File: verilog/urx_top.v */
// Serial receive extension: start-frame wake, break and auto-baud, one-wire, multiprocessor filter, infrared codec.
// Assumes a base receiver and transmitter on sys_clk (10 MHz) and an Avalon-MM master for the registers.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.vh"

module urx_top (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Pins and event input
	input wire serial_receive_pin,
	input wire event_rx_in,
	output wire serial_tx_pin,
	// Base transmitter and receiver
	input wire tx_bit,
	input wire tx_busy,
	input wire rx_busy,
	input wire rx_false_start,
	input wire rx_frame_done,
	input wire [8:0] rx_frame_data,
	input wire rx_stop1,
	output wire rx_line,
	output wire rx_frame_accept,
	output wire [15:0] baud_value,
	output wire double_speed_block,
	// Power manager
	input wire [1:0] sleep_state,
	input wire other_wake,
	output wire osc_request,
	output wire serial_clk_enable,
	output wire wake_request,
	output wire irq
);

	// ****************************************
	// Autobaud states
	// ****************************************
	localparam AB_IDLE = 2'h0;
	localparam AB_WAIT_START = 2'h1;
	localparam AB_MEASURE = 2'h2;
	localparam AB_CHECK = 2'h3;

	// ****************************************
	// Registers
	// ****************************************
	reg [`URX_CTRL_W-1:0] ctrl_r;
	reg [15:0] baud_r;
	reg [7:0] txpl_r;
	reg [6:0] rxpl_r;
	reg start_flag_r;
	reg rxc_flag_r;
	reg isf_flag_r;
	reg wfb_r;
	reg brk_flag_r;
	reg ack_r;
	reg [31:0] rdata_r;
	reg pin_s1_r;
	reg pin_s2_r;
	reg ev_s1_r;
	reg ev_s2_r;
	reg rx_prev_r;
	reg [15:0] low_cnt_r;
	reg wfb_low_r;
	reg [1:0] ab_state_r;
	reg [1:0] ab_state_nxt;
	reg [15:0] meas_r;
	reg [2:0] falls_r;
	reg [15:0] result_r;
	reg sfd_clk_r;
	reg accept_r;

	// ****************************************
	// Field views
	// ****************************************
	wire start_frame_detect_enable = ctrl_r[`URX_C_SFD];
	wire [1:0] receive_mode_select = ctrl_r[`URX_C_MODE_HI:`URX_C_MODE_LO];
	wire multiproc_filter_enable = ctrl_r[`URX_C_MPF];
	wire one_wire = ctrl_r[`URX_C_ONEWIRE];
	wire [1:0] comm_mode_field = ctrl_r[`URX_C_COMM_MODE_FIELD_HI:`URX_C_COMM_MODE_FIELD_LO];
	wire event_sel = ctrl_r[`URX_C_EVSEL];
	wire nine_bit = ctrl_r[`URX_C_NINE];
	wire rxs_ie = ctrl_r[`URX_C_RXSIE];
	wire rxc_ie = ctrl_r[`URX_C_RXCIE];
	wire [1:0] tx_mod = ctrl_r[`URX_C_TXM_HI:`URX_C_TXM_LO];
	wire infrared_codec = (comm_mode_field == `URX_COMM_MODE_FIELD_IR);
	wire lin_autobaud_mode = (receive_mode_select == `URX_MODE_LIN);
	wire generic_autobaud_mode = (receive_mode_select == `URX_MODE_GENERIC);
	wire [9:0] bit_clks = baud_r[15:`URX_FRAC_W];

	// ****************************************
	// Bus decode
	// ****************************************
	wire req = avs_read | avs_write;
	wire [2:0] reg_idx = avs_address[4:2];
	wire wr_go = avs_write & ack_r;
	wire wr_ctrl = wr_go & (reg_idx == `URX_REG_CTRL);
	wire wr_stat = wr_go & (reg_idx == `URX_REG_STATUS);
	wire wr_baud = wr_go & (reg_idx == `URX_REG_BAUD);
	wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] clr = avs_writedata & wmask;

	// One wait state per access; request held until waitrequest drops
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata = rdata_r;

	// Read data captured in the wait cycle; unmapped words read zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			if (avs_read & ~ack_r) begin
				case (reg_idx)
					`URX_REG_CTRL: rdata_r <= {19'h0_0000, ctrl_r};
					`URX_REG_STATUS: rdata_r <= {27'h000_0000, brk_flag_r, wfb_r, isf_flag_r, rxc_flag_r, start_flag_r};
					`URX_REG_BAUD: rdata_r <= {16'h0000, baud_r};
					`URX_REG_TXPL: rdata_r <= {24'h00_0000, txpl_r};
					`URX_REG_RXPL: rdata_r <= {25'h000_0000, rxpl_r};
					default: rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software settings
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= {`URX_CTRL_W{1'b0}};
			txpl_r <= `URX_TXPL_RST;
			rxpl_r <= `URX_RXPL_RST;
		end else if (wr_go) begin
			if (reg_idx == `URX_REG_CTRL)
				ctrl_r <= (avs_writedata[`URX_CTRL_W-1:0] & wmask[`URX_CTRL_W-1:0]) |
					(ctrl_r & ~wmask[`URX_CTRL_W-1:0]);
			if (reg_idx == `URX_REG_TXPL && avs_byteenable[0])
				txpl_r <= avs_writedata[7:0];
			if (reg_idx == `URX_REG_RXPL && avs_byteenable[0])
				rxpl_r <= avs_writedata[6:0];
		end
	end

	// ****************************************
	// Receive input path
	// ****************************************
	// Two-stage synchronisers for pin and event inputs
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			ev_s1_r <= 1'b1;
			ev_s2_r <= 1'b1;
		end else begin
			pin_s1_r <= serial_receive_pin;
			pin_s2_r <= pin_s1_r;
			ev_s1_r <= event_rx_in;
			ev_s2_r <= ev_s1_r;
		end
	end

	wire tx_pin_level;
	wire ir_rx_bit;
	wire rx_src = event_sel ? ev_s2_r : pin_s2_r;
	wire rx_dec = infrared_codec ? ir_rx_bit : rx_src;
	wire tx_line = infrared_codec ? tx_pin_level : tx_bit;

	// Infrared codec between the port and the pins
	urx_ircodec u_ir (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.bit_clks(bit_clks),
		.tx_mod(tx_mod),
		.tx_width(txpl_r),
		.rx_min_width(rxpl_r),
		.tx_bit(tx_bit),
		.tx_pin_level(tx_pin_level),
		.rx_pin_sync(rx_src),
		.rx_bit(ir_rx_bit)
	);

	assign rx_line = one_wire ? tx_bit : rx_dec;
	assign serial_tx_pin = tx_line;
	assign double_speed_block = infrared_codec;

	wire rx_fall = rx_prev_r & ~rx_line;
	wire rx_rise = ~rx_prev_r & rx_line;

	// ****************************************
	// Break detection
	// ****************************************
	wire [13:0] brk_limit = {4'h0, bit_clks} * `URX_BRK_BITS;
	wire autobaud_on = lin_autobaud_mode | generic_autobaud_mode;
	wire brk_len = ({2'b00, brk_limit} < low_cnt_r) & rx_rise;
	wire brk_wfb = wfb_r & wfb_low_r & rx_rise;
	wire brk_hit = autobaud_on & (brk_len | brk_wfb);

	// Low-time counter and wait-for-break edge tracking
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_prev_r <= 1'b1;
			low_cnt_r <= 16'h0000;
			wfb_low_r <= 1'b0;
		end else begin
			rx_prev_r <= rx_line;
			if (rx_line)
				low_cnt_r <= 16'h0000;
			else if (low_cnt_r != 16'hffff)
				low_cnt_r <= low_cnt_r + 16'h0001;
			if (!wfb_r || rx_rise)
				wfb_low_r <= 1'b0;
			else if (rx_fall)
				wfb_low_r <= 1'b1;
		end
	end

	// ****************************************
	// Sync field measurement
	// ****************************************
	wire meas_done = (ab_state_r == AB_MEASURE) & rx_fall & (falls_r + 3'h1 == `URX_SYNC_FALLS);
	wire meas_ovf = (ab_state_r == AB_MEASURE) & (meas_r > 16'hfff7);
	wire gen_ok = (result_r >= `URX_BAUD_MIN) & (result_r <= `URX_BAUD_MAX);
	wire lin_ok = rx_frame_done & (rx_frame_data[7:0] == `URX_SYNC_CHAR);
	wire ab_check = (ab_state_r == AB_CHECK) & rx_frame_done;
	wire baud_load = ab_check & (lin_autobaud_mode ? lin_ok : gen_ok);
	wire meas_cut = (ab_state_r == AB_MEASURE) & rx_frame_done & ~meas_done; // Character ended before fourth fall
	wire sync_bad = lin_autobaud_mode & ((ab_check & ~lin_ok) | meas_ovf | meas_cut);

	// Next state of the autobaud sequencer
	always @* begin
		ab_state_nxt = ab_state_r;
		case (ab_state_r)
			AB_IDLE: if (brk_hit) ab_state_nxt = AB_WAIT_START;
			AB_WAIT_START: if (rx_fall) ab_state_nxt = AB_MEASURE;
			AB_MEASURE: begin
				if (meas_done)
					ab_state_nxt = AB_CHECK;
				else if (meas_ovf | meas_cut)
					ab_state_nxt = AB_IDLE;
			end
			AB_CHECK: if (rx_frame_done) ab_state_nxt = AB_IDLE;
			default: ab_state_nxt = AB_IDLE;
		endcase
		if (!autobaud_on)
			ab_state_nxt = AB_IDLE;
	end

	// Counter steps eight per clock so eight bits give 64 times the bit clocks
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ab_state_r <= AB_IDLE;
			meas_r <= 16'h0000;
			falls_r <= 3'h0;
			result_r <= 16'h0000;
		end else begin
			ab_state_r <= ab_state_nxt;
			if (ab_state_r != AB_MEASURE) begin
				meas_r <= `URX_FRAC_STEP;
				falls_r <= 3'h0;
			end else begin
				meas_r <= meas_r + `URX_FRAC_STEP;
				if (rx_fall)
					falls_r <= falls_r + 3'h1;
			end
			if (meas_done)
				result_r <= meas_r;
		end
	end

	// Baud register: software write, or measured value once sync is valid
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			baud_r <= `URX_BAUD_RST;
		else if (baud_load)
			baud_r <= result_r;
		else if (wr_baud) begin
			if (avs_byteenable[0])
				baud_r[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				baud_r[15:8] <= avs_writedata[15:8];
		end
	end
	assign baud_value = baud_r;

	// ****************************************
	// Multiprocessor filter
	// ****************************************
	wire frame_type = nine_bit ? rx_frame_data[8] : rx_stop1;
	wire frame_keep = rx_frame_done & (~multiproc_filter_enable | frame_type);

	// Accepted frames go on to the receive buffer
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			accept_r <= 1'b0;
		else
			accept_r <= frame_keep;
	end
	assign rx_frame_accept = accept_r;

	// ****************************************
	// Start frame detection and power
	// ****************************************
	wire sfd_active = start_frame_detect_enable & (sleep_state == `URX_SLEEP_STANDBY) &
		(comm_mode_field == `URX_COMM_MODE_FIELD_ASYNC);
	wire sfd_edge = sfd_active & rx_fall;
	wire flag_wake = (rxs_ie & start_flag_r) | (rxc_ie & rxc_flag_r);

	// Serial clock held from start edge until frame ends, or start proves false with no other wake pending
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			sfd_clk_r <= 1'b0;
		else if (!sfd_active)
			sfd_clk_r <= 1'b0;
		else if (sfd_edge)
			sfd_clk_r <= 1'b1;
		else if (rx_false_start & ~other_wake)
			sfd_clk_r <= 1'b0;
		else if (rx_frame_done)
			sfd_clk_r <= 1'b0;
	end

	assign osc_request = (sleep_state != `URX_SLEEP_STANDBY) | sfd_clk_r | sfd_edge | tx_busy | rx_busy;
	assign serial_clk_enable = ~start_frame_detect_enable | (sleep_state != `URX_SLEEP_STANDBY) |
		sfd_clk_r | sfd_edge | tx_busy | rx_busy;
	assign wake_request = sfd_active & flag_wake;
	assign irq = flag_wake;

	// ****************************************
	// Status flags, set wins over clear; wait-for-break hardware clear wins over write
	// ****************************************
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			start_flag_r <= 1'b0;
			rxc_flag_r <= 1'b0;
			isf_flag_r <= 1'b0;
			wfb_r <= 1'b0;
			brk_flag_r <= 1'b0;
		end else begin
			if (sfd_edge)
				start_flag_r <= 1'b1;
			else if (wr_stat & clr[`URX_S_START])
				start_flag_r <= 1'b0;
			if (frame_keep)
				rxc_flag_r <= 1'b1;
			else if (wr_stat & clr[`URX_S_RXC])
				rxc_flag_r <= 1'b0;
			if (sync_bad)
				isf_flag_r <= 1'b1;
			else if (wr_stat & clr[`URX_S_ISF])
				isf_flag_r <= 1'b0;
			if (brk_hit)
				brk_flag_r <= 1'b1;
			else if (wr_stat & clr[`URX_S_BRK])
				brk_flag_r <= 1'b0;
			if (brk_wfb & autobaud_on)
				wfb_r <= 1'b0;
			else if (wr_stat & avs_byteenable[0])
				wfb_r <= avs_writedata[`URX_S_WFB];
		end
	end

endmodule
`default_nettype wire

/* File: verilog/urx_map.vh */
// Constants for the serial receive extension block: register map, field positions, reset values and timing.
// Assumes byte addressing on a 32-bit Avalon-MM bus, one register to an aligned word.
`ifndef URX_MAP_VH
`define URX_MAP_VH

// ****************************************
// Register word indices
// ****************************************
`define URX_REG_CTRL 3'h0
`define URX_REG_STATUS 3'h1
`define URX_REG_BAUD 3'h2
`define URX_REG_TXPL 3'h3
`define URX_REG_RXPL 3'h4

// ****************************************
// Control register fields
// ****************************************
`define URX_C_SFD 0
`define URX_C_MODE_LO 1
`define URX_C_MODE_HI 2
`define URX_C_MPF 3
`define URX_C_ONEWIRE 4
`define URX_C_COMM_MODE_FIELD_LO 5
`define URX_C_COMM_MODE_FIELD_HI 6
`define URX_C_EVSEL 7
`define URX_C_NINE 8
`define URX_C_RXSIE 9
`define URX_C_RXCIE 10
`define URX_C_TXM_LO 11
`define URX_C_TXM_HI 12
`define URX_CTRL_W 13

// ****************************************
// Status register fields
// ****************************************
`define URX_S_START 0
`define URX_S_RXC 1
`define URX_S_ISF 2
`define URX_S_WFB 3
`define URX_S_BRK 4

// ****************************************
// Encodings and reset values
// ****************************************
`define URX_MODE_NORMAL 2'h0
`define URX_MODE_GENERIC 2'h1
`define URX_MODE_LIN 2'h2
`define URX_COMM_MODE_FIELD_ASYNC 2'h0
`define URX_COMM_MODE_FIELD_IR 2'h2
`define URX_TXM_316 2'h0
`define URX_TXM_FIXED 2'h1
`define URX_TXM_OFF 2'h2
`define URX_SLEEP_ACTIVE 2'h0
`define URX_SLEEP_IDLE 2'h1
`define URX_SLEEP_STANDBY 2'h2
`define URX_SLEEP_PDOWN 2'h3
`define URX_BAUD_RST 16'h0400
`define URX_TXPL_RST 8'h00
`define URX_RXPL_RST 7'h00
`define URX_SYNC_CHAR 8'h55
`define URX_BAUD_MIN 16'h0064
`define URX_BAUD_MAX 16'h0fff
`define URX_BRK_BITS 14'h000b
`define URX_SYNC_FALLS 3'h4
`define URX_FRAC_STEP 16'h0008
`define URX_FRAC_W 6

`endif

/* File: verilog/urx_ircodec.v */
// Infrared pulse encoder and decoder for the serial port.
// Assumes tx_bit and rx_pin_sync are already in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.vh"

module urx_ircodec (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Settings
	input wire [9:0] bit_clks,
	input wire [1:0] tx_mod,
	input wire [7:0] tx_width,
	input wire [6:0] rx_min_width,
	// Transmit side
	input wire tx_bit,
	output wire tx_pin_level,
	// Receive side
	input wire rx_pin_sync,
	output wire rx_bit
);

	// ****************************************
	// Encoder
	// ****************************************
	reg [9:0] tx_cnt_r;
	reg [9:0] tx_w_r;
	reg tx_pulse_r;
	wire [11:0] w316 = ({2'b00, bit_clks} * 12'h003) >> 4;
	wire [9:0] w_nxt = (tx_mod == `URX_TXM_FIXED) ? {2'b00, tx_width} : w316[9:0];
	wire tx_bit_start = (tx_cnt_r == 10'h000);

	// Bit timer runs over zero bits; width is latched at each bit start
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_cnt_r <= 10'h000;
			tx_w_r <= 10'h000;
			tx_pulse_r <= 1'b0;
		end else begin
			if (tx_bit || tx_cnt_r + 10'h001 >= bit_clks)
				tx_cnt_r <= 10'h000;
			else
				tx_cnt_r <= tx_cnt_r + 10'h001;
			if (tx_bit_start)
				tx_w_r <= w_nxt;
			tx_pulse_r <= ~tx_bit && (tx_bit_start ? (w_nxt != 10'h000) : (tx_cnt_r < tx_w_r));
		end
	end

	// Pin shows the inverse of the pulse; no modulation passes data straight
	assign tx_pin_level = (tx_mod == `URX_TXM_OFF) ? tx_bit : ~tx_pulse_r;

	// ****************************************
	// Decoder
	// ****************************************
	reg [6:0] hi_cnt_r;
	reg [6:0] min_r;
	reg [9:0] hold_r;
	reg rx_bit_r;
	wire pulse = ~rx_pin_sync;

	// Pulse of enough width gives a zero held for one bit time
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hi_cnt_r <= 7'h00;
			min_r <= `URX_RXPL_RST;
			hold_r <= 10'h000;
			rx_bit_r <= 1'b1;
		end else begin
			if (!pulse) begin
				hi_cnt_r <= 7'h00;
				if (hold_r == 10'h000)
					min_r <= rx_min_width;
			end else if (hi_cnt_r != 7'h7f)
				hi_cnt_r <= hi_cnt_r + 7'h01;
			if (pulse && hi_cnt_r + 7'h01 >= min_r && hold_r == 10'h000) begin
				hold_r <= bit_clks;
				rx_bit_r <= 1'b0;
			end else if (hold_r != 10'h000)
				hold_r <= hold_r - 10'h001;
			else
				rx_bit_r <= 1'b1;
		end
	end

	assign rx_bit = rx_bit_r;

endmodule
`default_nettype wire

/* File: tb/urx_chk.sv */
// Checker for the serial receive extension, bound to urx_top.
// Sees only the top ports; one clock domain, reset active low.
`timescale 1ns/1ps
`default_nettype none
module urx_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Base side
	input wire logic tx_bit,
	input wire logic tx_busy,
	input wire logic rx_busy,
	input wire logic rx_false_start,
	input wire logic rx_frame_done,
	input wire logic rx_frame_accept,
	input wire logic serial_tx_pin,
	input wire logic double_speed_block,
	input wire logic [15:0] baud_value,
	// Power manager
	input wire logic [1:0] sleep_state,
	input wire logic other_wake,
	input wire logic osc_request,
	input wire logic serial_clk_enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Oscillator and serial clock
	osc_awake_a: assert property (sleep_state != 2'h2 |-> osc_request)
		else $error("oscillator off outside standby");
	osc_busy_a: assert property (tx_busy || rx_busy |-> osc_request && serial_clk_enable)
		else $error("clock stopped during transfer");
	false_start_a: assert property (rx_false_start && !other_wake && !tx_busy && !rx_busy &&
		sleep_state == 2'h2 |=> !serial_clk_enable) else $error("clock kept after false start");
	// Bus handshake
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	first_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state on new request");
	// Transmit path, frame filter and baud register
	tx_direct_a: assert property (!double_speed_block |-> serial_tx_pin == tx_bit)
		else $error("transmit pin altered outside infrared mode");
	accept_cause_a: assert property (rx_frame_accept |-> $past(rx_frame_done))
		else $error("frame accepted without a frame");
	baud_cause_a: assert property ($changed(baud_value) |-> $past(rx_frame_done) ||
		$past(rx_frame_done, 2) || $past(avs_write) && !$past(avs_waitrequest))
		else $error("baud changed without cause");
	// Main scenarios reached
	cover property (rx_frame_accept);
	cover property ($changed(baud_value));
	cover property (sleep_state == 2'h2 && serial_clk_enable && !rx_busy);
endmodule
bind urx_top urx_chk u_chk (.sys_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .tx_bit, .tx_busy,
	.rx_busy, .rx_false_start, .rx_frame_done, .rx_frame_accept, .serial_tx_pin, .double_speed_block,
	.baud_value, .sleep_state, .other_wake, .osc_request, .serial_clk_enable);
`default_nettype wire

/* File: tb/urx_node.sv */
// Remote serial node: drives the receive pin with frames, breaks and pulses.
// Assumes its tasks are called just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module urx_node (
	// Clock
	input wire logic sys_clk,
	// Line
	output logic line
);
	// Line idles high, as with a pull-up
	initial line = 1'b1;
	// Hold one level for n clocks
	task hold(input logic v, input integer n);
		line <= v;
		repeat (n) @(posedge sys_clk);
	endtask
	// Start bit low, data lowest bit first, two stop bits
	task frame(input logic [7:0] d, input integer t);
		logic [10:0] f;
		f = {2'b11, d, 1'b0};
		for (int k = 0; k < 11; k++)
			hold(f[k], t);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial receive extension.
// Drives bus, base strobes and power inputs; a node model drives the pin.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ****
	// Signals
	// ****
	logic sys_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0000_0000, q;
	logic [3:0] avs_byteenable = 4'hf;
	logic event_rx_in = 1'b1, tx_bit = 1'b1, tx_busy = 1'b0, rx_busy = 1'b0, lowseen = 1'b0;
	logic rx_false_start = 1'b0, rx_frame_done = 1'b0, rx_stop1 = 1'b0, other_wake = 1'b0;
	logic [8:0] rx_frame_data = 9'h000;
	logic [1:0] sleep_state = 2'h0;
	logic [15:0] b;
	wire [31:0] avs_readdata;
	wire [15:0] baud_value;
	wire avs_waitrequest, serial_receive_pin, serial_tx_pin, rx_line, rx_frame_accept;
	wire double_speed_block, osc_request, serial_clk_enable, wake_request, irq;
	integer n_fail = 0, compares = 0, seed = 32'h6d5e, cyc = 0, t, i;
	integer gl [4] = '{1, 2, 64, 63};
	// Design and far-side node
	urx_top dut (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .serial_receive_pin, .event_rx_in, .serial_tx_pin, .tx_bit,
		.tx_busy, .rx_busy, .rx_false_start, .rx_frame_done, .rx_frame_data, .rx_stop1, .rx_line,
		.rx_frame_accept, .baud_value, .double_speed_block, .sleep_state, .other_wake, .osc_request,
		.serial_clk_enable, .wake_request, .irq);
	urx_node node (.sys_clk, .line(serial_receive_pin));
	// Clock, hang limit and decoded-low monitor
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	always @(negedge sys_clk) if (rx_line === 1'b0) lowseen = 1'b1;
	// ****
	// Tasks and expectations
	// ****
	task final_report;
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		compares = compares + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Avalon-MM access held until waitrequest is sampled low at a rising edge
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= {a, 2'b00};
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [2:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [2:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q & m, e);
	endtask
	// One received frame from the base receiver
	task fd(input logic [8:0] d, input logic s);
		@(posedge sys_clk);
		rx_frame_data <= d;
		rx_stop1 <= s;
		rx_frame_done <= 1'b1;
		@(posedge sys_clk) rx_frame_done <= 1'b0;
	endtask
	task mp(input logic [8:0] d, input logic s, e);
		fd(d, s);
		@(negedge sys_clk) chk(rx_frame_accept, e);
	endtask
	// Break, then sync frame with t clocks a bit
	task ab(input integer brk, tt, input logic [7:0] d);
		node.hold(1'b0, brk);
		node.hold(1'b1, 3);
		node.frame(d, tt);
		fd({1'b0, d}, 1'b1);
		repeat (3) @(posedge sys_clk);
	endtask
	// Counted low clocks on the transmit pin for one zero bit
	task txp(input integer e);
		@(posedge sys_clk) tx_bit <= 1'b0;
		t = 0;
		repeat (12) @(negedge sys_clk) t = t + !serial_tx_pin;
		@(posedge sys_clk) tx_bit <= 1'b1;
		chk(t, e);
		repeat (20) @(posedge sys_clk);
	endtask
	task irx(input integer n, input logic e);
		lowseen = 1'b0;
		node.hold(1'b0, n);
		node.hold(1'b1, 30);
		chk(lowseen, e);
	endtask
	function automatic logic [15:0] nb(input integer tt, input logic [15:0] old, input logic gen);
		logic [31:0] v;
		v = tt * 64;
		nb = (gen && (v < 32'h0000_0064 || v > 32'h0000_0fff)) ? old : v[15:0];
	endfunction
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(2, 16'hffff, 16'h0400);
		rd(1, 16'h001f, 0);
		rd(3, 16'h00ff, 0);
		wr(5, 32'hffff_ffff);
		rd(5, 32'hffff_ffff, 0);
		wr(0, 16'h0010);
		repeat (4) begin
			q = $random(seed);
			@(posedge sys_clk) tx_bit <= q[0];
			@(negedge sys_clk) chk(rx_line, tx_bit);
		end
		@(posedge sys_clk) tx_bit <= 1'b1;
		wr(0, 16'h0080);
		for (i = 0; i < 2; i++) begin
			@(posedge sys_clk) event_rx_in <= i[0];
			node.hold(~i[0], 5);
			chk(rx_line, i[0]);
		end
		node.hold(1'b1, 3);
		wr(0, 16'h0008);
		mp(9'h012, 1'b0, 1'b0);
		mp(9'h034, 1'b1, 1'b1);
		wr(0, 16'h0108);
		mp(9'h1aa, 1'b0, 1'b1);
		mp(9'h0aa, 1'b1, 1'b0);
		wr(0, 16'h0000);
		q = $random(seed);
		mp({1'b0, q[7:0]}, 1'b0, 1'b1);
		wr(0, 16'h0201);
		node.hold(1'b0, 5);
		node.hold(1'b1, 5);
		rd(1, 1, 0);
		@(posedge sys_clk) sleep_state <= 2'h2;
		node.hold(1'b0, 5);
		chk(serial_clk_enable, 1);
		chk(irq, 1);
		chk(wake_request, 1);
		node.hold(1'b1, 3);
		rd(1, 1, 1);
		@(posedge sys_clk) rx_false_start <= 1'b1;
		@(posedge sys_clk) rx_false_start <= 1'b0;
		@(negedge sys_clk) chk(serial_clk_enable, 0);
		wr(1, 16'h0017);
		wr(0, 16'h0001);
		node.hold(1'b0, 5);
		chk(irq, 0);
		chk(wake_request, 0);
		node.hold(1'b1, 3);
		wr(0, 16'h0401);
		fd(9'h000, 1'b1);
		@(negedge sys_clk) chk(irq, 1);
		rd(1, 3, 3);
		@(posedge sys_clk) rx_busy <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rx_busy <= 1'b0;
		sleep_state <= 2'h0;
		wr(1, 16'h0017);
		wr(3, 16'h0005);
		wr(4, 16'h0004);
		wr(0, 16'h0040);
		@(negedge sys_clk) chk(double_speed_block, 1);
		txp(3);
		wr(0, 16'h0840);
		txp(5);
		t = 1 + ($unsigned($random(seed)) % 9);
		wr(3, t);
		txp(t);
		wr(0, 16'h1040);
		txp(12);
		irx(3, 1'b0);
		irx(4, 1'b1);
		wr(0, 16'h0004);
		b = 16'h0400;
		repeat (3) begin
			t = 10 + ($unsigned($random(seed)) % 31);
			ab(13 * b[15:6], t, 8'h55);
			b = nb(t, b, 1'b0);
			chk(baud_value, b);
		end
		ab(13 * b[15:6], 12, 8'h54);
		chk(baud_value, b);
		rd(1, 4, 4);
		rd(1, 16'h0010, 16'h0010);
		wr(1, 16'h0017);
		ab(10 * b[15:6], 12, 8'h55);
		chk(baud_value, b);
		rd(1, 16'h0010, 0);
		wr(0, 16'h0002);
		for (i = 0; i < 4; i++) begin
			ab(13 * b[15:6], gl[i], 8'h55);
			b = nb(gl[i], b, 1'b1);
			chk(baud_value, b);
		end
		wr(1, 16'h0008);
		ab(3, 20, 8'h55);
		b = nb(20, b, 1'b1);
		chk(baud_value, b);
		rd(1, 8, 0);
		final_report;
	end
endmodule
`default_nettype wire
